// ### rtl/psb_buf.v
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset from the parent.
`default_nettype none

module psb_buf #(
    parameter W = 8
) (
    input wire clk, // System clock
    input wire srst, // Synchronous reset, active high
    input wire in_valid, // Producer offers a word
    output wire in_ready, // Room for a word
    input wire [W-1:0] in_data, // Word offered
    output wire out_valid, // Head word present
    input wire out_ready, // Consumer takes the head
    output wire [W-1:0] out_data // Head word
);

    reg [W-1:0] slot [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = slot[rd_ptr];

    // Slots carry data only, so they need no reset
    always @(posedge clk) begin
        if (push) begin
            slot[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

`default_nettype wire

// ### rtl/psb_regs.vh
// Constants for the pipelined synchronous burst memory port.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef PSB_REGS_VH
`define PSB_REGS_VH

// Array shape: 512K words of four 9-bit lanes
`define PSB_ADDR_W 19
`define PSB_DEPTH 524288
`define PSB_WORD_W 36
`define PSB_LANE_W 9
`define PSB_LANES 4
`define PSB_LANE_MASK 36'h0000001ff

// Stored check bits per word
`define PSB_ECC_W 6
`define PSB_STORE_W 42

// Burst counter
`define PSB_BURST_W 2
`define PSB_BURST_STEP 2'h1
`define PSB_BURST_RST 2'h0

// Write buffer entry: {address, lane enables, data}
`define PSB_ENTRY_W 59
`define PSB_ENTRY_DATA_LSB 0
`define PSB_ENTRY_LANE_LSB 36
`define PSB_ENTRY_ADDR_LSB 40

// Reset values
`define PSB_DATA_RST 36'h000000000
`define PSB_ADDR_RST 19'h00000
`define PSB_LANES_RST 4'h0
`define PSB_SYNC_HI_RST 3'h7
`define PSB_SYNC_LO_RST 3'h0

// Write data lags its command by this many qualified edges
`define PSB_WR_DATA_LAG 2

`endif

// ### rtl/psb_sram.v
// Pipelined synchronous burst memory, 512K x 36, seen from inside the device.
// Assumes the host drives all synchronous pins from SYS_CLK; output enable
// and sleep request may change at any time and are synchronised here.
`include "psb_regs.vh"
`default_nettype none

// Function
// - Register all synchronous inputs on rising edge
// - Read data leaves through output registers
// - Suspend input high freezes the bus pipeline; buffered writes still drain
// - Back-to-back reads and writes, no waits
// - One word per cycle on data bus
// - Outputs float during write data phase
// - Writes complete by internal self-timed logic
// - Selected only when all three selects active
// - 512K words of 36 bits, addressed
// - Write begins on sampled write request
// - Write request sampled only when qualified
// - Active-low lane selects with write only
// - Each lane select gates nine bits
// - Linear or interleaved burst counter order
// - Error correction on stored words, transparent
// - Load low takes address, high advances
// - Select polarities low, high, low
// - Outputs float when deselected or writing
module psb_sram (
    input wire SYS_CLK, // 25 MHz system clock
    input wire SRST, // Synchronous reset, active high
    input wire [`PSB_ADDR_W-1:0] ADDR, // Word address
    input wire CHIP_SELECT_FIRST_N, // Chip select, active low
    input wire CHIP_SELECT_SECOND, // Chip select, active high
    input wire CHIP_SELECT_THIRD_N, // Chip select, active low
    input wire ADVANCE_OR_LOAD, // Low loads address, high advances burst
    input wire WRITE_REQUEST_N, // Write request, active low
    input wire LANE_A_WRITE_SELECT_N, // Lane a write select, active low
    input wire LANE_B_WRITE_SELECT_N, // Lane b write select, active low
    input wire LANE_C_WRITE_SELECT_N, // Lane c write select, active low
    input wire LANE_D_WRITE_SELECT_N, // Lane d write select, active low
    input wire CYCLE_SUSPEND_N, // Low lets the clock edge count
    input wire OUTPUT_ENABLE_N, // Asynchronous output enable, active low
    input wire SLEEP_REQUEST, // Asynchronous sleep request, active high
    input wire BURST_LINEAR, // High linear, low interleaved burst order
    input wire [`PSB_WORD_W-1:0] DATA_IN, // Data bus level seen at the pins
    output reg [`PSB_WORD_W-1:0] DATA_OUT, // Read data driven to the pins
    output reg DATA_OE // High while the device drives the data bus
);

    localparam OP_IDLE = 3'h1;
    localparam OP_READ = 3'h2;
    localparam OP_WRITE = 3'h4;

    reg [2:0] oe_sync;
    reg [2:0] sleep_sync;
    reg oe_n_q;
    reg sleep_q;

    reg [2:0] s1_op;
    reg [`PSB_ADDR_W-1:0] s1_base;
    reg [`PSB_BURST_W-1:0] s1_cnt;
    reg s1_linear;
    reg [`PSB_LANES-1:0] s1_lanes;

    reg s2_write;
    reg [`PSB_ADDR_W-1:0] s2_addr;
    reg [`PSB_LANES-1:0] s2_lanes;
    reg rd_phase;

    reg [`PSB_STORE_W-1:0] mem [0:`PSB_DEPTH-1];

    wire buf_in_ready;
    wire head_valid;
    wire [`PSB_ENTRY_W-1:0] head;

    // Slip codes: every data bit gets a distinct non-power-of-two syndrome
    function [`PSB_ECC_W-1:0] bit_code;
        input integer j;
        integer k;
        integer n;
        begin
            bit_code = 6'h00;
            n = 0;
            for (k = 3; k < 64; k = k + 1) begin
                if ((k & (k - 1)) != 0) begin
                    if (n == j) begin
                        bit_code = k[5:0];
                    end
                    n = n + 1;
                end
            end
        end
    endfunction

    function [`PSB_ECC_W-1:0] ecc_gen;
        input [`PSB_WORD_W-1:0] d;
        integer j;
        begin
            ecc_gen = 6'h00;
            for (j = 0; j < `PSB_WORD_W; j = j + 1) begin
                if (d[j]) begin
                    ecc_gen = ecc_gen ^ bit_code(j);
                end
            end
        end
    endfunction

    // single-bit correction on every array read
    function [`PSB_WORD_W-1:0] ecc_fix;
        input [`PSB_STORE_W-1:0] w;
        reg [`PSB_ECC_W-1:0] syn;
        integer j;
        begin
            ecc_fix = w[`PSB_WORD_W-1:0];
            syn = w[`PSB_STORE_W-1:`PSB_WORD_W] ^ ecc_gen(w[`PSB_WORD_W-1:0]);
            for (j = 0; j < `PSB_WORD_W; j = j + 1) begin
                if (syn == bit_code(j)) begin
                    ecc_fix[j] = ~ecc_fix[j];
                end
            end
        end
    endfunction

    // each lane select covers nine data bits; check bits are per word
    function [`PSB_WORD_W-1:0] merge;
        input [`PSB_WORD_W-1:0] old_w;
        input [`PSB_WORD_W-1:0] new_w;
        input [`PSB_LANES-1:0] lanes;
        reg [`PSB_WORD_W-1:0] m;
        integer i;
        begin
            m = `PSB_DATA_RST;
            for (i = 0; i < `PSB_LANES; i = i + 1) begin
                if (lanes[i]) begin
                    m = m | (`PSB_LANE_MASK << (`PSB_LANE_W * i));
                end
            end
            merge = (old_w & ~m) | (new_w & m);
        end
    endfunction

    // Three flops per asynchronous pin; a change counts once the last two agree
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            oe_sync <= `PSB_SYNC_HI_RST;
            sleep_sync <= `PSB_SYNC_LO_RST;
            oe_n_q <= 1'b1;
            sleep_q <= 1'b0;
        end else begin
            oe_sync <= {oe_sync[1:0], OUTPUT_ENABLE_N};
            sleep_sync <= {sleep_sync[1:0], SLEEP_REQUEST};
            if (oe_sync[1] == oe_sync[2]) begin
                oe_n_q <= oe_sync[2];
            end
            if (sleep_sync[1] == sleep_sync[2]) begin
                sleep_q <= sleep_sync[2];
            end
        end
    end

    // suspend, sleep or a full write buffer extend the current cycle
    wire qual = ~CYCLE_SUSPEND_N & ~sleep_q & buf_in_ready;

    wire sel_all = ~CHIP_SELECT_FIRST_N & CHIP_SELECT_SECOND & ~CHIP_SELECT_THIRD_N;

    wire [`PSB_LANES-1:0] lanes_in = ~{LANE_D_WRITE_SELECT_N, LANE_C_WRITE_SELECT_N,
                                       LANE_B_WRITE_SELECT_N, LANE_A_WRITE_SELECT_N};

    // burst sequence from the low address bits
    wire [`PSB_BURST_W-1:0] burst_low = s1_linear ? (s1_base[1:0] + s1_cnt)
                                                  : (s1_base[1:0] ^ s1_cnt);
    wire [`PSB_ADDR_W-1:0] s1_addr = {s1_base[`PSB_ADDR_W-1:2], burst_low};

    // command stage, taken only on qualified edges
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            s1_op <= OP_IDLE;
            s1_base <= `PSB_ADDR_RST;
            s1_cnt <= `PSB_BURST_RST;
            s1_linear <= 1'b0;
            s1_lanes <= `PSB_LANES_RST;
        end else if (qual) begin
            s1_lanes <= lanes_in;
            // load on low, advance on high
            if (!ADVANCE_OR_LOAD) begin
                s1_base <= ADDR;
                s1_cnt <= `PSB_BURST_RST;
                s1_linear <= BURST_LINEAR;
                if (!sel_all) begin
                    s1_op <= OP_IDLE;
                end else if (!WRITE_REQUEST_N) begin
                    s1_op <= OP_WRITE;
                end else begin
                    s1_op <= OP_READ;
                end
            end else begin
                s1_cnt <= s1_cnt + `PSB_BURST_STEP;
            end
        end
    end

    // Write data phase: one edge behind the write's address stage
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            s2_write <= 1'b0;
            s2_addr <= `PSB_ADDR_RST;
            s2_lanes <= `PSB_LANES_RST;
        end else if (qual) begin
            s2_addr <= s1_addr;
            s2_lanes <= s1_lanes;
            case (s1_op)
                OP_WRITE: s2_write <= 1'b1;
                default: s2_write <= 1'b0;
            endcase
        end
    end

    // data on the bus two qualified edges after the write command
    wire wr_push = qual & s2_write;
    wire [`PSB_ENTRY_W-1:0] wr_entry = {s2_addr, s2_lanes, DATA_IN};

    // Array writes drain behind the bus so a late lane merge never stalls it
    psb_buf #(
        .W(`PSB_ENTRY_W)
    ) u_wbuf (
        .clk(SYS_CLK),
        .srst(SRST),
        .in_valid(wr_push),
        .in_ready(buf_in_ready),
        .in_data(wr_entry),
        .out_valid(head_valid),
        .out_ready(~sleep_q),
        .out_data(head)
    );

    wire [`PSB_ADDR_W-1:0] head_addr = head[`PSB_ENTRY_W-1:`PSB_ENTRY_ADDR_LSB];
    wire [`PSB_LANES-1:0] head_lanes = head[`PSB_ENTRY_ADDR_LSB-1:`PSB_ENTRY_LANE_LSB];
    wire [`PSB_WORD_W-1:0] head_data = head[`PSB_ENTRY_LANE_LSB-1:`PSB_ENTRY_DATA_LSB];

    // self-timed read-modify-write keeps unselected lanes and regenerates check bits
    wire [`PSB_WORD_W-1:0] drain_word = merge(ecc_fix(mem[head_addr]), head_data,
                                              head_lanes);
    always @(posedge SYS_CLK) begin
        if (head_valid && !sleep_q) begin
            mem[head_addr] <= {ecc_gen(drain_word), drain_word};
        end
    end

    // reads see writes still in the buffer or arriving on this edge
    reg [`PSB_WORD_W-1:0] rd_word;
    always @* begin
        rd_word = ecc_fix(mem[s1_addr]);
        if (head_valid && head_addr == s1_addr) begin
            rd_word = merge(rd_word, head_data, head_lanes);
        end
        if (s2_write && s2_addr == s1_addr) begin
            rd_word = merge(rd_word, DATA_IN, s2_lanes);
        end
    end

    wire next_rd_phase = qual ? (s1_op == OP_READ) : rd_phase;

    // read data only through the output register
    // word loads on the edge after its address was taken
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            DATA_OUT <= `PSB_DATA_RST;
            rd_phase <= 1'b0;
            DATA_OE <= 1'b0;
        end else begin
            if (qual && s1_op == OP_READ) begin
                DATA_OUT <= rd_word;
            end
            rd_phase <= next_rd_phase;
            // deselect and its first cycle out never drive
            // Suspend freezes the drive too; sleep still releases the bus
            if (qual || sleep_q) begin
                DATA_OE <= next_rd_phase & ~oe_n_q & ~sleep_q;
            end
        end
    end

endmodule

`default_nettype wire

// ### verification/psb_host_bus.sv
// Host side model: resolves the data bus and drives write data.
// Assumes the bench flags each write command as it presents it.
`include "psb_regs.vh"
`default_nettype none
module psb_host_bus (
    input wire logic clk, // System clock
    input wire logic srst, // Reset, active high
    input wire logic qual, // Edge is qualified
    input wire logic wr_cmd, // Write command presented
    input wire logic [`PSB_WORD_W-1:0] wr_data, // Data for that write
    input wire logic dev_oe, // Device drives the bus
    input wire logic [`PSB_WORD_W-1:0] dev_data, // Device drive value
    output logic [`PSB_WORD_W-1:0] bus // Level at the pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`PSB_WORD_W:0] st1, st2;
    logic [`PSB_WORD_W-1:0] last;
    // data slot moves on qualified edges
    always_ff @(posedge clk) begin
        if (srst) begin
            st1 <= 37'h0;
            st2 <= 37'h0;
        end else if (qual) begin
            st1 <= {wr_cmd, wr_data};
            st2 <= st1;
        end
        last <= srst ? 36'h0 : bus;
    end
    always_comb begin
        if (dev_oe)
            bus = dev_data;
        else if (st2[`PSB_WORD_W])
            bus = st2[`PSB_WORD_W-1:0];
        else
            bus = ~last;
    end
endmodule
`default_nettype wire

// ### verification/psb_sram_props.sv
// Checker on the memory port pins, bound into psb_sram.
// Assumes one clock and SRST synchronous, active high.
`include "psb_regs.vh"
`default_nettype none
module psb_sram_props (
    input wire logic SYS_CLK, // Clock
    input wire logic SRST, // Reset
    input wire logic CHIP_SELECT_FIRST_N, // Select one
    input wire logic CHIP_SELECT_SECOND, // Select two
    input wire logic CHIP_SELECT_THIRD_N, // Select three
    input wire logic ADVANCE_OR_LOAD, // Low loads
    input wire logic WRITE_REQUEST_N, // Low writes
    input wire logic CYCLE_SUSPEND_N, // High freezes
    input wire logic OUTPUT_ENABLE_N, // Async enable
    input wire logic [`PSB_WORD_W-1:0] DATA_OUT, // Read data
    input wire logic DATA_OE // Bus drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] oe_age;
    wire q = !CYCLE_SUSPEND_N;
    wire ld = q && !ADVANCE_OR_LOAD;
    wire sel = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N;
    // Enable passes a synchroniser, so only a long-settled low counts
    always_ff @(posedge SYS_CLK) begin
        if (SRST || OUTPUT_ENABLE_N)
            oe_age <= 3'h0;
        else if (oe_age != 3'h7)
            oe_age <= oe_age + 3'h1;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    a_suspend_oe_held:
        assert property (CYCLE_SUSPEND_N |=> $stable(DATA_OE)) else $error("drive moved in suspend");
    a_suspend_out_held:
        assert property (CYCLE_SUSPEND_N |=> $stable(DATA_OUT)) else $error("data moved in suspend");
    a_deselect_float:
        assert property (ld && !sel ##1 q |=> !DATA_OE) else $error("driven after deselect");
    a_write_phase_float:
        assert property (ld && sel && !WRITE_REQUEST_N ##1 q |=> !DATA_OE)
            else $error("driven in write data phase");
    a_read_drive_lat:
        assert property (ld && sel && WRITE_REQUEST_N && oe_age == 3'h7 ##1 q && !OUTPUT_ENABLE_N
            |=> DATA_OE) else $error("read data not driven");
    a_enable_mask:
        assert property (OUTPUT_ENABLE_N [*6] |=> !DATA_OE) else $error("driven with enable high");
    a_rise_qualified:
        assert property ($rose(DATA_OE) |-> $past(q)) else $error("drive rose on unqualified edge");
    a_reset_quiet:
        assert property (disable iff (1'b0) SRST |=> !DATA_OE && DATA_OUT == 36'h0)
            else $error("outputs not cleared by reset");
    c_read: cover property (ld && sel && WRITE_REQUEST_N ##2 DATA_OE);
    c_write_read: cover property (ld && sel && !WRITE_REQUEST_N ##1 ld && sel && WRITE_REQUEST_N);
    c_suspend: cover property (CYCLE_SUSPEND_N [*3]);
endmodule
bind psb_sram psb_sram_props u_psb_sram_props (.SYS_CLK, .SRST, .CHIP_SELECT_FIRST_N,
    .CHIP_SELECT_SECOND, .CHIP_SELECT_THIRD_N, .ADVANCE_OR_LOAD, .WRITE_REQUEST_N,
    .CYCLE_SUSPEND_N, .OUTPUT_ENABLE_N, .DATA_OUT, .DATA_OE);
`default_nettype wire

// ### verification/tb_top.sv
// Directed bench for the burst memory port with a host bus model.
// Assumes psb_sram, psb_host_bus and the bound checker compiled first.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [18:0] BASE = 19'h7fffc;
    logic clk, srst, cs1_n, cs2, cs3_n, adv, we_n, sus_n, oe_n, lin, wr_cmd;
    logic [18:0] addr;
    logic [3:0] lanes_n;
    logic [35:0] wr_data;
    logic [35:0] pat [4];
    logic [1:0] bad;
    wire [35:0] din, dout;
    wire doe;
    int num_errors, comparisons;
    psb_sram u_psb_sram (.SYS_CLK(clk), .SRST(srst), .ADDR(addr), .CHIP_SELECT_FIRST_N(cs1_n),
        .CHIP_SELECT_SECOND(cs2), .CHIP_SELECT_THIRD_N(cs3_n), .ADVANCE_OR_LOAD(adv),
        .WRITE_REQUEST_N(we_n), .LANE_A_WRITE_SELECT_N(lanes_n[0]),
        .LANE_B_WRITE_SELECT_N(lanes_n[1]), .LANE_C_WRITE_SELECT_N(lanes_n[2]),
        .LANE_D_WRITE_SELECT_N(lanes_n[3]), .CYCLE_SUSPEND_N(sus_n), .OUTPUT_ENABLE_N(oe_n),
        .SLEEP_REQUEST(1'b0), .BURST_LINEAR(lin), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe));
    psb_host_bus u_psb_host_bus (.clk(clk), .srst(srst), .qual(!sus_n), .wr_cmd(wr_cmd),
        .wr_data(wr_data), .dev_oe(doe), .dev_data(dout), .bus(din));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // Op 0 deselect, 1 read, 2 write, 3 advance; bad drops one select
    task automatic cyc(input logic [1:0] op, input logic [18:0] a, input logic [3:0] ln,
        input logic [35:0] d);
        @(negedge clk);
        adv = (op == 2'h3);
        cs1_n = (op == 2'h0) || (bad == 2'h1);
        cs2 = (bad != 2'h2);
        cs3_n = (bad == 2'h3);
        we_n = (op != 2'h2);
        wr_cmd = (op == 2'h2);
        addr = a;
        lanes_n = ln;
        wr_data = d;
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        repeat (n) cyc(2'h0, 19'h0, 4'hf, 36'h0);
    endtask
    task automatic rd(input logic [18:0] a, input logic [35:0] e);
        cyc(2'h1, a, 4'hf, 36'h0);
        idle(1);
        #1;
        check(dout, e);
        check({35'h0, doe}, 36'h1);
    endtask
    task automatic t_fill;
        for (int i = 0; i < 4; i++) begin
            pat[i] = 36'h123456789 + 36'h111111111 * i;
            cyc(2'h2, {BASE[18:2], i[1:0]}, 4'h0, pat[i]);
        end
        idle(1);
        for (int i = 0; i < 4; i++)
            rd({BASE[18:2], i[1:0]}, pat[i]);
    endtask
    task automatic t_burst;
        for (int m = 0; m < 2; m++) begin
            @(negedge clk);
            lin = m[0];
            cyc(2'h1, {BASE[18:2], 2'h1}, 4'hf, 36'h0);
            for (int k = 1; k < 5; k++) begin
                cyc(k < 4 ? 2'h3 : 2'h0, 19'h0, 4'hf, 36'h0);
                #1;
                check(dout, pat[m ? k % 4 : 1 ^ (k - 1)]);
            end
        end
    endtask
    task automatic t_lanes;
        cyc(2'h2, BASE, 4'h0, 36'hfffffffff);
        cyc(2'h2, BASE, 4'ha, 36'h0);
        idle(2);
        rd(BASE, 36'hff803fe00);
    endtask
    task automatic t_deselect;
        for (int b = 1; b < 4; b++) begin
            bad = b[1:0];
            cyc(2'h2, BASE, 4'h0, 36'h0);
            bad = 2'h0;
            idle(1);
            #1;
            check({35'h0, doe}, 36'h0);
            idle(1);
            rd(BASE, 36'hff803fe00);
        end
    endtask
    task automatic t_suspend;
        cyc(2'h2, {BASE[18:2], 2'h2}, 4'h0, 36'h5a5a5a5a5);
        @(negedge clk);
        sus_n = 1'b1;
        cyc(2'h2, {BASE[18:2], 2'h3}, 4'h0, 36'h0);
        idle(1);
        @(negedge clk);
        sus_n = 1'b0;
        idle(1);
        rd({BASE[18:2], 2'h2}, 36'h5a5a5a5a5);
        rd({BASE[18:2], 2'h3}, pat[3]);
    endtask
    task automatic t_turn;
        cyc(2'h2, BASE, 4'h0, 36'h0a0a0a0a0);
        cyc(2'h1, {BASE[18:2], 2'h1}, 4'hf, 36'h0);
        cyc(2'h2, {BASE[18:2], 2'h3}, 4'h0, 36'h0c0c0c0c0);
        #1;
        check(dout, pat[1]);
        cyc(2'h1, BASE, 4'hf, 36'h0);
        idle(1);
        #1;
        check(dout, 36'h0a0a0a0a0);
        rd({BASE[18:2], 2'h3}, 36'h0c0c0c0c0);
    endtask
    task automatic t_oe;
        @(negedge clk);
        oe_n = 1'b1;
        idle(6);
        cyc(2'h1, BASE, 4'hf, 36'h0);
        idle(1);
        #1;
        check({35'h0, doe}, 36'h0);
        @(negedge clk);
        oe_n = 1'b0;
        idle(8);
    endtask
    task automatic final_report;
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        {srst, cs1_n, cs2, cs3_n, adv, we_n} = 6'h3b;
        {sus_n, oe_n, lin, wr_cmd, bad} = 6'h08;
        addr = 19'h0;
        lanes_n = 4'hf;
        wr_data = 36'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        idle(8);
        t_fill();
        t_burst();
        t_lanes();
        t_deselect();
        t_suspend();
        t_turn();
        t_oe();
        final_report();
    end
endmodule
`default_nettype wire
